// *** hpcd_consts.svh ***
// Purpose: Constants of the host port command and DMA block.
// Assumes: Host port byte addresses are three bits, core bus is APB.
// Notes:   Field positions are bit indexes inside their byte or word.
`ifndef HPCD_CONSTS_SVH
`define HPCD_CONSTS_SVH

// Host side byte register addresses.
`define HPCD_HA_CTRL      3'h0
`define HPCD_HA_CVR       3'h1
`define HPCD_HA_STAT      3'h2
`define HPCD_HA_IVR       3'h3
`define HPCD_HA_UNUSED    3'h4
`define HPCD_HA_HIGH      3'h5
`define HPCD_HA_MID       3'h6
`define HPCD_HA_LOW       3'h7

// Host side control fields.
`define HPCD_ICR_RX_REQUEST_ENABLE     0
`define HPCD_ICR_TX_REQUEST_ENABLE     1
`define HPCD_ICR_HF0      3
`define HPCD_ICR_HM_LO    5
`define HPCD_ICR_HM_HI    6
`define HPCD_CVR_HC       7
`define HPCD_HV_RESET     5'h12

// Core side APB byte offsets.
`define HPCD_PA_CTRL      12'h000
`define HPCD_PA_STAT      12'h004
`define HPCD_PA_RX        12'h008
`define HPCD_PA_TX        12'h00C

// Core side control fields.
`define HPCD_HCR_RXIE     0
`define HPCD_HCR_TXIE     1
`define HPCD_HCR_CMDIE    2

// Exception vector addresses.
`define HPCD_VEC_RX       16'h0020
`define HPCD_VEC_TX       16'h0022

// Strap capture delay after reset release, in cycles.
`define HPCD_STRAP_WAIT   2'h3

`endif

// *** hpcd_pkg.sv ***
// Purpose: Types shared by the host port command and DMA block.
// Assumes: Pin group is sampled as one unit by the synchroniser.
// Notes:   Active low pins carry _n.
package hpcd_pkg;

  typedef struct packed {
    logic       strap;
    logic       ack_n;
    logic       strobe_n;
    logic       rw;
    logic [2:0] addr;
    logic [7:0] data;
  } hpcd_pins_t;

  typedef struct packed {
    logic        req;
    logic [15:0] vector;
  } hpcd_exc_t;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_RX,
    SRC_TX,
    SRC_CMD
  } hpcd_src_t;

endpackage : hpcd_pkg

// *** hpcd_sync.sv ***
// Purpose: Two flip-flop synchroniser for the host pin group.
// Assumes: Pins idle high, so reset loads ones.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module hpcd_sync (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Pins.
  input  wire hpcd_pkg::hpcd_pins_t pins_in,
  output hpcd_pkg::hpcd_pins_t     pins_out
);
  import hpcd_pkg::*;

  localparam int W = $bits(hpcd_pins_t);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] raw;

  assign raw      = pins_in;
  assign pins_out = sync_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i] <= 1'b1;
        sync_q[i] <= 1'b1;
      end else begin
        meta_q[i] <= raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

endmodule : hpcd_sync

// *** hpcd_top.sv ***
// Purpose: Byte-wide host port with command vectors and host DMA.
// Assumes: Core registers over APB, zero wait states.
// Notes:   Host pins are asynchronous and pass hpcd_sync first.
//
// How it works
// - Raise receive, transmit and command exceptions.
// - Command vector address is number doubled.
// - Command request sets core pending bit.
// - Command exception only with command enable.
// - Core acknowledge clears request and pending.
// - Host clearing request withdraws the command.
// - Byte register four reads zero.
// - Low transmit byte write starts word move.
// - Boot source strap visible to boot code.
// - Host flag zero visible to stop boot.
// - Transmit exception when empty and enabled.
// - Host low receive byte read clears full.
// - Core word moves to host receive bytes.
// - Receive request enable drives request pin.
// - DMA byte address from internal counter.
// - Polled access allowed with acknowledge off.
// - DMA request while empty, drop on acknowledge.
// - DMA byte latched when acknowledge deasserts.
// - Non-low DMA byte increments counter, rerequests.
// - Low DMA byte reloads counter from size.
// - Low byte clears empty; core read clears full.
// - Transmit request enable alone, with nonzero size, selects host to core DMA.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "hpcd_consts.svh"
module hpcd_top (
  // Clock and reset.
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave.
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Host pins.
  input  wire hpcd_pkg::hpcd_pins_t pins,
  output logic      [7:0]           port_data_out,
  output logic                      port_data_oe,
  output logic                      request_pin_n,
  // Core exception logic.
  input  wire logic                 core_irq_enable,
  input  wire logic                 exc_ack,
  output hpcd_pkg::hpcd_exc_t       exc
);
  import hpcd_pkg::*;

  hpcd_pins_t s;
  logic       strobe_prev_q;
  logic       ack_prev_q;
  logic [7:0] ctrl_q;
  logic       hc_q;
  logic [4:0] hv_q;
  logic [7:0] ivr_q;
  logic [7:0] tx_byte_q [3];
  logic       host_tx_empty_q;
  logic [2:0] dma_addr_q;
  logic       core_rx_full_q;
  logic [23:0] core_rx_q;
  logic       core_tx_empty_q;
  logic [23:0] core_tx_q;
  logic [23:0] rx_q;
  logic       host_rx_full_q;
  logic [2:0] core_ctrl_q;
  logic [1:0] strap_cnt_q;
  logic       boot_ext_q;
  logic [7:0] port_data_q;
  logic [31:0] prdata_q;
  hpcd_exc_t  exc_q;
  hpcd_src_t  src_q;
  hpcd_src_t  src_d;
  logic       strb_end;
  logic       ack_end;
  logic       host_wr;
  logic       host_rd;
  logic       dma_h2c;
  logic       dma_wr;
  logic       tx_wr;
  logic [2:0] tx_wr_addr;
  logic       ctrl_wr;
  logic       h2c_xfer;
  logic       c2h_xfer;
  logic       apb_wr;
  logic       apb_rd;
  logic       core_rx_rd;
  logic       core_tx_wr;
  logic       mapped;
  logic       cmd_ack;
  logic       request;
  logic [2:0] dma_start;
  logic [1:0] hm;
  logic [1:0] hm_sel;
  logic [7:0] host_rdata;
  logic [31:0] apb_rdata;

  hpcd_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins_in  (pins),
    .pins_out (s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_q <= 1'b1;
      ack_prev_q    <= 1'b1;
    end else begin
      strobe_prev_q <= s.strobe_n;
      ack_prev_q    <= s.ack_n;
    end
  end

  // Host accesses complete on the strobe's trailing edge.
  assign strb_end = !strobe_prev_q && s.strobe_n;
  assign ack_end  = !ack_prev_q && s.ack_n;
  assign host_wr  = strb_end && !s.rw && s.ack_n;
  assign host_rd  = strb_end && s.rw && s.ack_n;
  assign hm       = {ctrl_q[`HPCD_ICR_HM_HI], ctrl_q[`HPCD_ICR_HM_LO]};
  assign dma_h2c  = ctrl_q[`HPCD_ICR_TX_REQUEST_ENABLE] && !ctrl_q[`HPCD_ICR_RX_REQUEST_ENABLE]
                    && (hm != 2'h0);
  assign dma_wr   = dma_h2c && ack_end;
  assign tx_wr_addr = dma_wr ? dma_addr_q : s.addr;
  assign tx_wr    = dma_wr || (host_wr && s.addr >= `HPCD_HA_HIGH);
  assign ctrl_wr  = host_wr && s.addr == `HPCD_HA_CTRL;
  assign h2c_xfer = !host_tx_empty_q && !core_rx_full_q;
  assign c2h_xfer = !host_rx_full_q && !core_tx_empty_q && !core_tx_wr;
  assign cmd_ack  = exc_ack && src_q == SRC_CMD;
  // A control write reloads the counter from the size being written.
  assign hm_sel   = ctrl_wr ? {s.data[`HPCD_ICR_HM_HI],
                               s.data[`HPCD_ICR_HM_LO]} : hm;

  always_comb begin
    unique case (hm_sel)
      2'h2:    dma_start = `HPCD_HA_MID;
      2'h3:    dma_start = `HPCD_HA_LOW;
      default: dma_start = `HPCD_HA_HIGH;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      ivr_q  <= 8'h00;
    end else if (host_wr) begin
      if (s.addr == `HPCD_HA_CTRL) begin
        ctrl_q <= s.data;
      end
      if (s.addr == `HPCD_HA_IVR) begin
        ivr_q <= s.data;
      end
    end
  end

  // A host write of the vector register wins over a core acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hc_q <= 1'b0;
      hv_q <= `HPCD_HV_RESET;
    end else if (host_wr && s.addr == `HPCD_HA_CVR) begin
      hc_q <= s.data[`HPCD_CVR_HC];
      hv_q <= s.data[4:0];
    end else if (cmd_ack) begin
      hc_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_q[0] <= 8'h00;
      tx_byte_q[1] <= 8'h00;
      tx_byte_q[2] <= 8'h00;
    end else if (tx_wr) begin
      unique case (tx_wr_addr)
        `HPCD_HA_HIGH: tx_byte_q[0] <= s.data;
        `HPCD_HA_MID:  tx_byte_q[1] <= s.data;
        default:       tx_byte_q[2] <= s.data;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_tx_empty_q <= 1'b1;
    end else if (h2c_xfer) begin
      host_tx_empty_q <= 1'b1;
    end else if (tx_wr && tx_wr_addr == `HPCD_HA_LOW) begin
      host_tx_empty_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_addr_q <= `HPCD_HA_HIGH;
    end else if (ctrl_wr || h2c_xfer) begin
      dma_addr_q <= dma_start;
    end else if (dma_wr) begin
      if (dma_addr_q == `HPCD_HA_LOW) begin
        dma_addr_q <= dma_start;
      end else begin
        dma_addr_q <= dma_addr_q + 3'h1;
      end
    end
  end

  // Word toward the core; the core read frees the receive register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rx_full_q    <= 1'b0;
      core_rx_q <= 24'h000000;
    end else if (h2c_xfer) begin
      core_rx_full_q    <= 1'b1;
      core_rx_q <= {tx_byte_q[0], tx_byte_q[1], tx_byte_q[2]};
    end else if (core_rx_rd) begin
      core_rx_full_q    <= 1'b0;
    end
  end

  // Word toward the host.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_tx_empty_q    <= 1'b1;
      core_tx_q <= 24'h000000;
    end else if (core_tx_wr) begin
      core_tx_empty_q    <= 1'b0;
      core_tx_q <= pwdata[23:0];
    end else if (c2h_xfer) begin
      core_tx_empty_q    <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_rx_full_q <= 1'b0;
      rx_q   <= 24'h000000;
    end else if (c2h_xfer) begin
      host_rx_full_q <= 1'b1;
      rx_q   <= core_tx_q;
    end else if (host_rd && s.addr == `HPCD_HA_LOW) begin
      host_rx_full_q <= 1'b0;
    end
  end

  // Boot source strap is taken once the synchroniser has filled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      boot_ext_q  <= 1'b0;
    end else if (strap_cnt_q != `HPCD_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `HPCD_STRAP_WAIT - 2'h1) begin
        boot_ext_q <= s.strap;
      end
    end
  end

  always_comb begin
    unique case (s.addr)
      `HPCD_HA_CTRL: host_rdata = ctrl_q;
      `HPCD_HA_CVR:  host_rdata = {hc_q, 2'h0, hv_q};
      `HPCD_HA_STAT: host_rdata = {request, 5'h00, host_tx_empty_q, host_rx_full_q};
      `HPCD_HA_IVR:  host_rdata = ivr_q;
      `HPCD_HA_HIGH: host_rdata = rx_q[23:16];
      `HPCD_HA_MID:  host_rdata = rx_q[15:8];
      `HPCD_HA_LOW:  host_rdata = rx_q[7:0];
      default:       host_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_q <= 8'h00;
    end else begin
      port_data_q <= host_rdata;
    end
  end

  assign port_data_out = port_data_q;
  assign port_data_oe  = !s.strobe_n && s.rw && s.ack_n;

  // The acknowledge release cycle is masked so a finished low byte
  // cannot glitch the request before the empty flag falls.
  always_comb begin
    if (dma_h2c) begin
      request = host_tx_empty_q && s.ack_n && ack_prev_q;
    end else begin
      request = (ctrl_q[`HPCD_ICR_RX_REQUEST_ENABLE] && host_rx_full_q)
                || (ctrl_q[`HPCD_ICR_TX_REQUEST_ENABLE] && host_tx_empty_q);
    end
  end
  assign request_pin_n = !request;

  // APB slave, zero wait states.
  assign apb_wr     = psel && penable && pwrite;
  assign apb_rd     = psel && penable && !pwrite;
  assign core_rx_rd = apb_rd && paddr == `HPCD_PA_RX;
  assign core_tx_wr = apb_wr && paddr == `HPCD_PA_TX;
  assign mapped     = paddr == `HPCD_PA_CTRL || paddr == `HPCD_PA_STAT
                      || paddr == `HPCD_PA_RX || paddr == `HPCD_PA_TX;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;
  assign prdata     = prdata_q;

  always_comb begin
    unique case (paddr)
      `HPCD_PA_CTRL: apb_rdata = {29'h0, core_ctrl_q};
      `HPCD_PA_STAT: apb_rdata = {27'h0, boot_ext_q,
                                  ctrl_q[`HPCD_ICR_HF0],
                                  hc_q,
                                  core_tx_empty_q, core_rx_full_q};
      `HPCD_PA_RX:   apb_rdata = {8'h00, core_rx_q};
      default:       apb_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable) begin
      prdata_q <= apb_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctrl_q <= 3'h0;
    end else if (apb_wr && paddr == `HPCD_PA_CTRL) begin
      core_ctrl_q <= pwdata[2:0];
    end
  end

  // Exception source, receive first, then transmit, then command.
  always_comb begin
    src_d = SRC_NONE;
    if (core_irq_enable) begin
      if (core_rx_full_q && core_ctrl_q[`HPCD_HCR_RXIE]) begin
        src_d = SRC_RX;
      end else if (core_tx_empty_q && core_ctrl_q[`HPCD_HCR_TXIE]) begin
        src_d = SRC_TX;
      end else if (hc_q && core_ctrl_q[`HPCD_HCR_CMDIE]) begin
        src_d = SRC_CMD;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= SRC_NONE;
      exc_q <= '0;
    end else begin
      src_q     <= src_d;
      exc_q.req <= src_d != SRC_NONE;
      unique case (src_d)
        SRC_RX:   exc_q.vector <= `HPCD_VEC_RX;
        SRC_TX:   exc_q.vector <= `HPCD_VEC_TX;
        SRC_CMD:  exc_q.vector <= {10'h000, hv_q, 1'b0};
        SRC_NONE: exc_q.vector <= 16'h0000;
      endcase
    end
  end
  assign exc = exc_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_cmd_vec_double: assert property (
    exc.req && src_q == SRC_CMD |->
      exc.vector == {10'h000, $past(hv_q), 1'b0})
    else $error("command vector is not twice the number");
  a_rx_vector: assert property (
    exc.req && src_q == SRC_RX |-> exc.vector == `HPCD_VEC_RX)
    else $error("receive exception vector wrong");
  a_cmd_needs_en: assert property (
    exc.req && src_q == SRC_CMD |->
      $past(core_ctrl_q[`HPCD_HCR_CMDIE] && hc_q))
    else $error("command exception without enable");
  a_ack_clears_cmd: assert property (
    cmd_ack && !(host_wr && s.addr == `HPCD_HA_CVR) |=> !hc_q)
    else $error("acknowledge did not clear command request");
  a_withdraw_cmd: assert property (
    !hc_q |=> !(exc.req && src_q == SRC_CMD))
    else $error("withdrawn command still raised");
  a_tx_exception: assert property (
    exc.req && src_q == SRC_TX |->
      exc.vector == `HPCD_VEC_TX && $past(core_tx_empty_q))
    else $error("transmit exception without empty flag");
  a_unused_zero: assert property (
    s.addr == `HPCD_HA_UNUSED |=> port_data_out == 8'h00)
    else $error("unused host register not zero");
  a_low_starts_move: assert property (
    tx_wr && tx_wr_addr == `HPCD_HA_LOW && !core_rx_full_q && !h2c_xfer
      |=> !host_tx_empty_q ##1 core_rx_full_q && host_tx_empty_q)
    else $error("low byte write did not move the word");
  a_rxl_clears: assert property (
    host_rd && s.addr == `HPCD_HA_LOW && !c2h_xfer |=> !host_rx_full_q)
    else $error("low receive byte read kept full flag");
  a_core_to_host: assert property (
    c2h_xfer |=> host_rx_full_q && core_tx_empty_q && rx_q == $past(core_tx_q))
    else $error("core word not moved to host bytes");
  a_ack_drops_req: assert property (
    dma_h2c && !s.ack_n |-> !request)
    else $error("request held during acknowledge");
  a_dma_increment: assert property (
    dma_wr && dma_addr_q != `HPCD_HA_LOW && !ctrl_wr && !h2c_xfer
      |=> dma_addr_q == $past(dma_addr_q) + 3'h1)
    else $error("DMA counter did not step");

  c_cmd_taken: cover property (exc.req && src_q == SRC_CMD && exc_ack);
  c_dma_low_byte: cover property (dma_wr && dma_addr_q == `HPCD_HA_LOW);
  c_core_to_host: cover property (c2h_xfer ##[1:50] host_rd);

endmodule : hpcd_top

// *** hpcd_host_model.sv ***
// Purpose: Host processor and DMA controller on the host port pins.
// Assumes: Pins change just after a rising pclk edge.
// Notes:   Released data lines show the inverse of the last byte.
`timescale 1ns/1ps
module hpcd_host_model (
  // Clock.
  input  wire logic            pclk,
  // Host pins.
  output hpcd_pkg::hpcd_pins_t pins,
  input  wire logic [7:0]      port_data_out,
  input  wire logic            port_data_oe,
  input  wire logic            request_pin_n
);
  import hpcd_pkg::*;

  hpcd_pins_t drv = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 8'hA5};

  // The data wire carries the port's byte whenever the port drives it.
  always_comb begin
    pins = drv;
    if (port_data_oe) begin
      pins.data = port_data_out;
    end
  end

  // Polled access: acknowledge stays high throughout.
  task automatic access(input logic rd, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    drv.rw       <= rd;
    drv.addr     <= a;
    drv.data     <= d;
    drv.strobe_n <= 1'b0;
    repeat (6) @(posedge pclk);
    q = port_data_out;
    drv.strobe_n <= 1'b1;
    repeat (5) @(posedge pclk);
    drv.data <= ~d;
  endtask : access

  // One DMA byte, acknowledged once a request is shown or after 100 cycles without one.
  task automatic dma(input logic [7:0] b, output logic dropped);
    int n;
    n = 0;
    while (request_pin_n !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    drv.rw    <= 1'b0;
    drv.data  <= b;
    drv.ack_n <= 1'b0;
    repeat (4) @(posedge pclk);
    dropped = request_pin_n;
    drv.ack_n <= 1'b1;
    repeat (4) @(posedge pclk);
    drv.data <= ~b;
  endtask : dma
endmodule : hpcd_host_model

// *** hpcd_tb_top.sv ***
// Purpose: Self-checking bench for the host port block.
// Assumes: APB answers within 50 cycles; strap pin stays high.
// Notes:   Random data from a fixed seed.
`timescale 1ns/1ps
`include "hpcd_consts.svh"
module hpcd_tb_top;
  import hpcd_pkg::*;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  hpcd_pins_t  pins;
  logic [7:0]  port_data_out;
  logic        port_data_oe;
  logic        request_pin_n;
  logic        core_irq_enable = 1'b0;
  logic        exc_ack = 1'b0;
  hpcd_exc_t   exc;
  int          failures = 0;
  int          tests_run = 0;
  logic [7:0]  txb [5:7];
  logic [31:0] rd;
  logic        err;
  logic [7:0]  q;
  logic        dr;
  logic [4:0]  n;
  logic [23:0] w;

  always #5 pclk = ~pclk;

  hpcd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .request_pin_n(request_pin_n), .core_irq_enable(core_irq_enable),
    .exc_ack(exc_ack), .exc(exc));

  hpcd_host_model host (.pclk(pclk), .pins(pins),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .request_pin_n(request_pin_n));

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask : tick

  task automatic wrap_up();
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end

  initial begin
    w = 24'($urandom(89));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    tick(6);
    apb(1'b0, `HPCD_PA_STAT, 32'h0);
    chk("reset status", 32'h12, rd);
    host.access(1'b1, `HPCD_HA_CVR, 8'h00, q);
    chk("reset vector", 32'h12, 32'(q));
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("ready", 32'h1, 32'(pready));
    chk("port drive idle", 32'h0, 32'(port_data_oe));
    host.access(1'b0, `HPCD_HA_UNUSED, 8'hFF, q);
    host.access(1'b1, `HPCD_HA_UNUSED, 8'h00, q);
    chk("unused byte", 32'h0, 32'(q));
    host.access(1'b0, `HPCD_HA_CTRL, 8'h08, q);
    tick(4);
    apb(1'b0, `HPCD_PA_STAT, 32'h0);
    chk("flag zero", 32'h1A, rd);
    host.access(1'b0, `HPCD_HA_CTRL, 8'h00, q);
    // Polled word from host to core, low byte last.
    for (int i = 5; i < 8; i++) begin
      txb[i] = 8'($urandom);
      host.access(1'b0, 3'(i), txb[i], q);
    end
    tick(4);
    apb(1'b1, `HPCD_PA_CTRL, 32'h1);
    core_irq_enable <= 1'b1;
    tick(3);
    chk("rx exception", 32'h10020, 32'(exc));
    apb(1'b0, `HPCD_PA_RX, 32'h0);
    chk("rx word", {8'h00, txb[5], txb[6], txb[7]}, rd);
    apb(1'b0, `HPCD_PA_STAT, 32'h0);
    chk("rx full cleared", 32'h12, rd);
    // Word from core to host.
    apb(1'b1, `HPCD_PA_CTRL, 32'h2);
    tick(3);
    chk("tx exception", 32'h10022, 32'(exc));
    apb(1'b1, `HPCD_PA_CTRL, 32'h0);
    apb(1'b1, `HPCD_PA_TX, {8'h00, w});
    host.access(1'b0, `HPCD_HA_CTRL, 8'h01, q);
    tick(4);
    chk("request on data", 32'h0, 32'(request_pin_n));
    for (int i = 5; i < 8; i++) begin
      host.access(1'b1, 3'(i), 8'h00, q);
      chk("rx byte", 32'(w >> (8 * (7 - i)) & 24'hFF), 32'(q));
    end
    host.access(1'b1, `HPCD_HA_STAT, 8'h00, q);
    chk("host rx full", 32'h0, 32'(q[0]));
    chk("request idle", 32'h1, 32'(request_pin_n));
    host.access(1'b0, `HPCD_HA_CTRL, 8'h00, q);
    // Command: masked, withdrawn, then taken.
    n = 5'($urandom_range(31, 1));
    host.access(1'b0, `HPCD_HA_CVR, {3'b100, n}, q);
    tick(4);
    apb(1'b0, `HPCD_PA_STAT, 32'h0);
    chk("pending", 32'h1, 32'(rd[2]));
    chk("masked command", 32'h0, 32'(exc.req));
    host.access(1'b0, `HPCD_HA_CVR, {3'b000, n}, q);
    apb(1'b1, `HPCD_PA_CTRL, 32'h4);
    tick(3);
    chk("withdrawn", 32'h0, 32'(exc.req));
    host.access(1'b0, `HPCD_HA_CVR, {3'b100, n}, q);
    tick(4);
    chk("command vector", {15'h0, 1'b1, 10'h0, n, 1'b0}, 32'(exc));
    @(posedge pclk);
    exc_ack <= 1'b1;
    @(posedge pclk);
    exc_ack <= 1'b0;
    tick(4);
    chk("command taken", 32'h0, 32'(exc.req));
    host.access(1'b1, `HPCD_HA_CVR, 8'h00, q);
    chk("request bit", 32'h0, 32'(q[7]));
    apb(1'b1, `HPCD_PA_CTRL, 32'h0);
    // DMA host to core in 24, 16 and 8 bit words.
    for (int s = 1; s < 4; s++) begin
      host.access(1'b0, `HPCD_HA_CTRL, {1'b0, 2'(s), 5'b00010}, q);
      for (int i = 4 + s; i < 8; i++) begin
        txb[i] = 8'($urandom);
        host.dma(txb[i], dr);
        chk("request on ack", 32'h1, 32'(dr));
      end
      tick(4);
      chk("request again", 32'h0, 32'(request_pin_n));
      apb(1'b0, `HPCD_PA_RX, 32'h0);
      chk("dma word", {8'h00, txb[5], txb[6], txb[7]}, rd);
    end
    host.access(1'b0, `HPCD_HA_CTRL, 8'h00, q);
    wrap_up();
  end
endmodule : hpcd_tb_top
